// ===== src/dac_frame_defines.vh
// Shared constants for the converter frame writer
`ifndef DAC_FRAME_DEFINES_VH
`define DAC_FRAME_DEFINES_VH

// ==============================================
// Timing
`define CLK_PERIOD_NS 100
`define SCK_HALF_NS 500
`define SCK_HALF_CYC ((`SCK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_SETUP_NS 500
`define CS_SETUP_CYC ((`CS_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CS_HOLD_NS 500
`define CS_HOLD_CYC ((`CS_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==============================================
// Frame shape
`define BYTE_BITS 8
`define FRAME_BITS 16
`define BYTE_COUNT_INIT 4'h8
`define FRAME_COUNT_INIT 5'h10

// ==============================================
// Bit-banged port layout
`define PORT_CS_BIT 0
`define PORT_CLK_BIT 1
`define PORT_DATA_BIT 2
`define PORT_IDLE 3'h1

// ==============================================
// Reset values
`define CS_N_RESET 1'b1
`define SCK_RESET 1'b0

`endif

// ===== src/spi_byte_shifter.v
// Eight-bit serial shifter, master or slave, clock idle low, sample on rise
`timescale 1ns/10ps
`include "dac_frame_defines.vh"
module spi_byte_shifter
(
	input wire clk_i,
	input wire reset_i,
	input wire master_i,
	input wire load_i,
	input wire [7:0] tx_byte_i,
	input wire sck_s_i,
	input wire mosi_s_i,
	input wire miso_s_i,
	input wire ss_n_s_i,
	output wire sck_o,
	output wire mosi_o,
	output wire miso_o,
	output wire [7:0] rx_byte_o,
	output wire done_o,
	output wire active_o
);
	localparam integer HALF_W = `SCK_HALF_CYC;
	localparam [7:0] HALF = HALF_W[7:0];
	reg [7:0] shift_reg;
	reg [3:0] cnt_reg;
	reg [7:0] timer_reg;
	reg sck_reg;
	reg sck_prev_reg;
	reg in_bit_reg;
	reg active_reg;
	reg done_reg;
	wire rise = sck_s_i & ~sck_prev_reg;
	wire fall = ~sck_s_i & sck_prev_reg;

	// ==============================================
	// Shift engine
	always @(posedge clk_i)
	begin
		sck_prev_reg <= sck_s_i;
		done_reg <= 1'b0;
		if (reset_i)
		begin
			shift_reg <= 8'h00;
			cnt_reg <= `BYTE_COUNT_INIT;
			timer_reg <= 8'h00;
			sck_reg <= `SCK_RESET;
			in_bit_reg <= 1'b0;
			active_reg <= 1'b0;
		end
		else if (master_i)
		begin
			if (!active_reg)
			begin
				sck_reg <= 1'b0;
				if (load_i)
				begin
					shift_reg <= tx_byte_i;
					cnt_reg <= `BYTE_COUNT_INIT;
					timer_reg <= HALF;
					active_reg <= 1'b1;
				end
			end
			else if (timer_reg != 8'h01)
				timer_reg <= timer_reg - 8'h01;
			else
			begin
				timer_reg <= HALF;
				if (!sck_reg)
				begin
					sck_reg <= 1'b1;
					in_bit_reg <= miso_s_i;
				end
				else
				begin
					sck_reg <= 1'b0;
					shift_reg <= {shift_reg[6:0], in_bit_reg};
					cnt_reg <= cnt_reg - 4'h1;
					if (cnt_reg == 4'h1)
					begin
						active_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
			end
		end
		else
		begin
			sck_reg <= 1'b0;
			if (ss_n_s_i)
			begin
				// Preload reply byte while deselected
				shift_reg <= tx_byte_i;
				cnt_reg <= `BYTE_COUNT_INIT;
				active_reg <= 1'b0;
			end
			else
			begin
				active_reg <= 1'b1;
				if (rise)
					in_bit_reg <= mosi_s_i;
				else if (fall)
				begin
					shift_reg <= {shift_reg[6:0], in_bit_reg};
					cnt_reg <= (cnt_reg == 4'h1) ? `BYTE_COUNT_INIT : cnt_reg - 4'h1;
					done_reg <= (cnt_reg == 4'h1);
				end
			end
		end
	end

	assign sck_o = sck_reg;
	assign mosi_o = shift_reg[7];
	assign miso_o = shift_reg[7];
	assign rx_byte_o = shift_reg;
	assign done_o = done_reg;
	assign active_o = active_reg;
endmodule // spi_byte_shifter

// ===== src/bitbang_frame_driver.v
// Sixteen-bit frame driven on three plain port bits
`timescale 1ns/10ps
`include "dac_frame_defines.vh"
module bitbang_frame_driver
(
	input wire clk_i,
	input wire reset_i,
	input wire start_i,
	input wire [7:0] addr_i,
	input wire [7:0] data_i,
	output wire [2:0] port_o,
	output wire done_o
);
	localparam integer HALF_W = `SCK_HALF_CYC;
	localparam [7:0] HALF = HALF_W[7:0];
	localparam [2:0] B_IDLE = 3'h0;
	localparam [2:0] B_SET = 3'h1;
	localparam [2:0] B_HIGH = 3'h2;
	localparam [2:0] B_LOW = 3'h3;
	localparam [2:0] B_SHIFT = 3'h4;
	reg [2:0] state_reg;
	reg [7:0] addr_reg;
	reg [7:0] data_reg;
	reg [4:0] count_reg;
	reg [7:0] timer_reg;
	reg cs_n_reg;
	reg clk_reg;
	reg sdo_reg;
	reg done_reg;
	wire tick = (timer_reg == 8'h01);

	// ==============================================
	// Bit loop
	always @(posedge clk_i)
	begin
		done_reg <= 1'b0;
		if (reset_i)
		begin
			state_reg <= B_IDLE;
			addr_reg <= 8'h00;
			data_reg <= 8'h00;
			count_reg <= 5'h00;
			timer_reg <= 8'h00;
			cs_n_reg <= `CS_N_RESET;
			clk_reg <= `SCK_RESET;
			sdo_reg <= 1'b0;
		end
		else
		begin
			timer_reg <= tick ? HALF : timer_reg - 8'h01;
			case (state_reg)
				B_IDLE:
				begin
					clk_reg <= 1'b0;
					if (start_i)
					begin
						cs_n_reg <= 1'b0;
						count_reg <= `FRAME_COUNT_INIT;
						addr_reg <= addr_i;
						data_reg <= data_i;
						timer_reg <= HALF;
						state_reg <= B_SET;
					end
				end
				B_SET:
				begin
					sdo_reg <= addr_reg[7];
					if (tick)
						state_reg <= B_HIGH;
				end
				B_HIGH:
				begin
					clk_reg <= 1'b1;
					if (tick)
						state_reg <= B_LOW;
				end
				B_LOW:
				begin
					clk_reg <= 1'b0;
					if (tick)
						state_reg <= B_SHIFT;
				end
				B_SHIFT:
				begin
					// Address byte goes out first; the data byte's top bit is carried into the address byte
					data_reg <= {data_reg[6:0], 1'b0};
					addr_reg <= {addr_reg[6:0], data_reg[7]};
					count_reg <= count_reg - 5'h01;
					timer_reg <= HALF;
					if (count_reg == 5'h01)
					begin
						cs_n_reg <= 1'b1;
						done_reg <= 1'b1;
						state_reg <= B_IDLE;
					end
					else
						state_reg <= B_SET;
				end
				default:
					state_reg <= B_IDLE;
			endcase
		end
	end

	assign port_o = {sdo_reg, clk_reg, cs_n_reg};
	assign done_o = done_reg;
endmodule // bitbang_frame_driver

// ===== src/dac_serial_frame_writer.v
// Top: frame writer for an eight-channel serial converter
// How it works
// - Master shifts each byte out MSB first
// - Clock pin drives as master, listens as slave
// - Data changes one edge, sampled the other
// - Return line input as master, output as slave
// - Slave select gates slave transfers only
// - Master; data valid at rising clock edge
// - Frame is two back-to-back bytes, sixteen bits
// - Chip select falls before first bit
// - First byte address pointer, second data
// - Chip select rises after both bytes
// - Wait each byte's completion before continuing
// - Port bits: select, clock, data
// - Bit-banged start: select low, count sixteen
// - Top address bit onto data before clock
// - Clock high then low, once per bit
// - Shift data byte, carry into address byte
// - Count down sixteen bits, then raise select
`timescale 1ns/10ps
`include "dac_frame_defines.vh"
module dac_serial_frame_writer
(
	input wire CLK_I,
	input wire RESET_I,
	input wire START_I,
	input wire [7:0] ADDR_I,
	input wire [7:0] DATA_I,
	input wire USE_BITBANG_I,
	input wire MASTER_I,
	input wire [7:0] SLAVE_TX_I,
	input wire SCK_I,
	output reg SCK_O,
	output reg SCK_OE_N_O,
	input wire MOSI_I,
	output reg MOSI_O,
	output reg MOSI_OE_N_O,
	input wire MISO_I,
	output reg MISO_O,
	output reg MISO_OE_N_O,
	input wire SS_N_I,
	output reg CS_N_O,
	output reg [2:0] PORT_O,
	output reg BUSY_O,
	output reg DONE_O,
	output reg [7:0] SLAVE_RX_O,
	output reg SLAVE_RX_VALID_O
);
	// ==============================================
	// Timing counts, cut to the timer width on purpose
	localparam integer SETUP_W = `CS_SETUP_CYC;
	localparam integer HOLD_W = `CS_HOLD_CYC;
	localparam [7:0] SETUP = SETUP_W[7:0];
	localparam [7:0] HOLD = HOLD_W[7:0];

	// ==============================================
	// Sequencer states
	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_SETUP = 3'h1;
	localparam [2:0] S_LOAD_A = 3'h2;
	localparam [2:0] S_WAIT_A = 3'h3;
	localparam [2:0] S_LOAD_D = 3'h4;
	localparam [2:0] S_WAIT_D = 3'h5;
	localparam [2:0] S_HOLD = 3'h6;
	localparam [2:0] S_BANG = 3'h7;

	// ==============================================
	// Pin synchronisers
	// The serial clock from outside is only seen through these; edges are found one stage later
	reg sck_m_reg;
	reg sck_s_reg;
	reg mosi_m_reg;
	reg mosi_s_reg;
	reg miso_m_reg;
	reg miso_s_reg;
	reg ss_m_reg;
	reg ss_s_reg;

	always @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			sck_m_reg <= 1'b0;
			sck_s_reg <= 1'b0;
			mosi_m_reg <= 1'b0;
			mosi_s_reg <= 1'b0;
			miso_m_reg <= 1'b0;
			miso_s_reg <= 1'b0;
			ss_m_reg <= 1'b1;
			ss_s_reg <= 1'b1;
		end
		else
		begin
			sck_m_reg <= SCK_I;
			sck_s_reg <= sck_m_reg;
			mosi_m_reg <= MOSI_I;
			mosi_s_reg <= mosi_m_reg;
			miso_m_reg <= MISO_I;
			miso_s_reg <= miso_m_reg;
			ss_m_reg <= SS_N_I;
			ss_s_reg <= ss_m_reg;
		end
	end

	// ==============================================
	// Frame state
	reg [2:0] state_reg;
	reg [2:0] state_next;
	reg [7:0] timer_reg;
	reg [7:0] timer_next;
	reg [7:0] addr_reg;
	reg [7:0] data_reg;
	reg master_reg;
	reg cs_n_reg;
	reg cs_n_next;
	reg busy_reg;
	reg busy_next;
	reg done_reg;
	reg done_next;
	reg load_sh;
	reg [7:0] tx_sh;
	reg start_bb;

	wire sh_sck;
	wire sh_mosi;
	wire sh_miso;
	wire [7:0] sh_rx;
	wire sh_done;
	wire sh_active;
	wire [2:0] bb_port;
	wire bb_done;

	// Configuration only changes between frames, so a half-sent byte never sees a role swap
	// A selected slave keeps the shifter active; swapping then would start a phantom master byte
	always @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			master_reg <= 1'b1;
			addr_reg <= 8'h00;
			data_reg <= 8'h00;
		end
		else if (state_reg == S_IDLE && !sh_active)
		begin
			master_reg <= MASTER_I;
			if (START_I)
			begin
				addr_reg <= ADDR_I;
				data_reg <= DATA_I;
			end
		end
	end

	// ==============================================
	// Sequencer
	always @*
	begin
		state_next = state_reg;
		timer_next = timer_reg;
		cs_n_next = cs_n_reg;
		busy_next = busy_reg;
		done_next = 1'b0;
		load_sh = 1'b0;
		tx_sh = master_reg ? addr_reg : SLAVE_TX_I;
		start_bb = 1'b0;
		case (state_reg)
			S_IDLE:
			begin
				if (START_I && master_reg)
				begin
					busy_next = 1'b1;
					if (USE_BITBANG_I)
					begin
						start_bb = 1'b1;
						state_next = S_BANG;
					end
					else
					begin
						cs_n_next = 1'b0;
						timer_next = SETUP;
						state_next = S_SETUP;
					end
				end
			end
			S_SETUP:
			begin
				// Select settles low before the first clock edge
				if (timer_reg == 8'h01)
					state_next = S_LOAD_A;
				else
					timer_next = timer_reg - 8'h01;
			end
			S_LOAD_A:
			begin
				load_sh = 1'b1;
				tx_sh = addr_reg;
				state_next = S_WAIT_A;
			end
			S_WAIT_A:
			begin
				if (sh_done)
					state_next = S_LOAD_D;
			end
			S_LOAD_D:
			begin
				load_sh = 1'b1;
				tx_sh = data_reg;
				state_next = S_WAIT_D;
			end
			S_WAIT_D:
			begin
				if (sh_done)
				begin
					timer_next = HOLD;
					state_next = S_HOLD;
				end
			end
			S_HOLD:
			begin
				if (timer_reg == 8'h01)
				begin
					cs_n_next = 1'b1;
					busy_next = 1'b0;
					done_next = 1'b1;
					state_next = S_IDLE;
				end
				else
					timer_next = timer_reg - 8'h01;
			end
			S_BANG:
			begin
				start_bb = 1'b0;
				if (bb_done)
				begin
					busy_next = 1'b0;
					done_next = 1'b1;
					state_next = S_IDLE;
				end
			end
			default:
				state_next = S_IDLE;
		endcase
	end

	always @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			state_reg <= S_IDLE;
			timer_reg <= 8'h00;
			cs_n_reg <= `CS_N_RESET;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			cs_n_reg <= cs_n_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	// ==============================================
	// Engines
	spi_byte_shifter u_shifter
	(
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.master_i(master_reg),
		.load_i(load_sh),
		.tx_byte_i(tx_sh),
		.sck_s_i(sck_s_reg),
		.mosi_s_i(mosi_s_reg),
		.miso_s_i(miso_s_reg),
		.ss_n_s_i(ss_s_reg),
		.sck_o(sh_sck),
		.mosi_o(sh_mosi),
		.miso_o(sh_miso),
		.rx_byte_o(sh_rx),
		.done_o(sh_done),
		.active_o(sh_active)
	);

	// Bit-banged path reads the request directly, as the latched copy lands one cycle late
	bitbang_frame_driver u_bitbang
	(
		.clk_i(CLK_I),
		.reset_i(RESET_I),
		.start_i(start_bb),
		.addr_i(ADDR_I),
		.data_i(DATA_I),
		.port_o(bb_port),
		.done_o(bb_done)
	);

	// ==============================================
	// Output registers
	// Every pin is delayed by the same single stage, so data-to-clock spacing is kept
	always @(posedge CLK_I)
	begin
		if (RESET_I)
		begin
			SCK_O <= `SCK_RESET;
			SCK_OE_N_O <= 1'b0;
			MOSI_O <= 1'b0;
			MOSI_OE_N_O <= 1'b0;
			MISO_O <= 1'b0;
			MISO_OE_N_O <= 1'b1;
			CS_N_O <= `CS_N_RESET;
			PORT_O <= `PORT_IDLE;
			BUSY_O <= 1'b0;
			DONE_O <= 1'b0;
			SLAVE_RX_O <= 8'h00;
			SLAVE_RX_VALID_O <= 1'b0;
		end
		else
		begin
			SCK_O <= master_reg & sh_sck;
			SCK_OE_N_O <= ~master_reg;
			MOSI_O <= master_reg & sh_mosi;
			MOSI_OE_N_O <= ~master_reg;
			MISO_O <= ~master_reg & sh_miso;
			MISO_OE_N_O <= master_reg | ss_s_reg;
			CS_N_O <= cs_n_reg;
			PORT_O <= bb_port;
			BUSY_O <= busy_reg;
			DONE_O <= done_reg;
			SLAVE_RX_VALID_O <= ~master_reg & sh_done & sh_active;
			// Received byte stands until the next one lands
			if (~master_reg & sh_done)
				SLAVE_RX_O <= sh_rx;
		end
	end
endmodule // dac_serial_frame_writer

// ===== verification/dac_frame_props.sv
// Port checker for the frame writer
`timescale 1ns/10ps
module dac_frame_props
(
	input wire CLK_I,
	input wire RESET_I,
	input wire START_I,
	input wire MASTER_I,
	input wire SCK_O,
	input wire SCK_OE_N_O,
	input wire MOSI_O,
	input wire MOSI_OE_N_O,
	input wire MISO_OE_N_O,
	input wire CS_N_O,
	input wire [2:0] PORT_O,
	input wire BUSY_O,
	input wire DONE_O
);
default clocking cb @(posedge CLK_I); endclocking
default disable iff (RESET_I);
// ==========================================
// Clock rise counts, judged at select release
reg [4:0] spi_cnt_reg;
reg [4:0] bb_cnt_reg;
reg sck_d_reg;
reg bclk_d_reg;
always @(posedge CLK_I)
begin
	sck_d_reg <= SCK_O;
	bclk_d_reg <= PORT_O[1];
	if (RESET_I || CS_N_O)
		spi_cnt_reg <= 5'h00;
	else if (SCK_O && !sck_d_reg)
		spi_cnt_reg <= spi_cnt_reg + 5'h01;
	if (RESET_I || PORT_O[0])
		bb_cnt_reg <= 5'h00;
	else if (PORT_O[1] && !bclk_d_reg)
		bb_cnt_reg <= bb_cnt_reg + 5'h01;
end
property p_cs_release;
	$rose(CS_N_O) |-> spi_cnt_reg == 5'h10 && DONE_O && !BUSY_O;
endproperty
a_cs_release: assert property (p_cs_release) else $error("spi frame end wrong");
property p_bb_release;
	$rose(PORT_O[0]) |-> bb_cnt_reg == 5'h10;
endproperty
a_bb_release: assert property (p_bb_release) else $error("port frame count wrong");
property p_sck_rest;
	CS_N_O |-> !SCK_O;
endproperty
a_sck_rest: assert property (p_sck_rest) else $error("clock not at rest");
property p_cs_setup;
	$fell(CS_N_O) |-> !SCK_O [*5];
endproperty
a_cs_setup: assert property (p_cs_setup) else $error("select setup short");
property p_mosi_hold;
	SCK_O |-> $stable(MOSI_O);
endproperty
a_mosi_hold: assert property (p_mosi_hold) else $error("data moved at clock high");
property p_port_hold;
	PORT_O[1] |-> $stable(PORT_O[2]);
endproperty
a_port_hold: assert property (p_port_hold) else $error("port data moved");
property p_port_rest;
	PORT_O[0] |-> !PORT_O[1];
endproperty
a_port_rest: assert property (p_port_rest) else $error("port clock not at rest");
property p_take;
	START_I && MASTER_I && !BUSY_O && !DONE_O && CS_N_O && PORT_O[0] |-> ##[1:3] BUSY_O;
endproperty
a_take: assert property (p_take) else $error("request not taken");
property p_oe_master;
	!SCK_OE_N_O |-> MISO_OE_N_O && !MOSI_OE_N_O;
endproperty
a_oe_master: assert property (p_oe_master) else $error("pin direction wrong");
property p_done_pulse;
	DONE_O |=> !DONE_O && !BUSY_O;
endproperty
a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
c_spi: cover property ($rose(CS_N_O));
c_bb: cover property ($rose(PORT_O[0]));
c_slave: cover property ($fell(MISO_OE_N_O));
endmodule // dac_frame_props
bind dac_serial_frame_writer dac_frame_props props_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .START_I(START_I),
	.MASTER_I(MASTER_I), .SCK_O(SCK_O), .SCK_OE_N_O(SCK_OE_N_O), .MOSI_O(MOSI_O), .MOSI_OE_N_O(MOSI_OE_N_O),
	.MISO_OE_N_O(MISO_OE_N_O), .CS_N_O(CS_N_O), .PORT_O(PORT_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O));

// ===== verification/dac_chip_model.sv
// Behavioural eight-channel converter on its serial input
`timescale 1ns/10ps
module dac_chip_model
(
	input wire cs_n_i,
	input wire sck_i,
	input wire din_i,
	output wire dout_o,
	output reg [15:0] word_o,
	output reg [4:0] bits_o,
	output reg [7:0] frames_o,
	output reg [5:0] mode_o
);
reg [15:0] sh_reg;
reg [4:0] cnt_reg;
reg [7:0] ch_reg [0:7];
integer i;
initial
begin
	frames_o = 8'h00;
	mode_o = 6'h00;
end
// Driven high while deselected: reads high once released
assign dout_o = cs_n_i ? 1'b1 : sh_reg[15];
always @(negedge cs_n_i)
	cnt_reg = 5'h00;
always @(posedge sck_i)
	if (!cs_n_i)
	begin
		sh_reg = {sh_reg[14:0], din_i};
		cnt_reg = cnt_reg + 5'h01;
	end
// Frame takes effect only at select release
always @(posedge cs_n_i)
begin
	word_o = sh_reg;
	bits_o = cnt_reg;
	frames_o = frames_o + 8'h01;
	if (sh_reg[15:8] != 8'h00)
	begin
		for (i = 0; i < 8; i = i + 1)
			if (sh_reg[8 + i])
				ch_reg[i] = sh_reg[7:0];
	end
	else if (sh_reg[7])
		mode_o = sh_reg[5:0];
end
endmodule // dac_chip_model

// ===== verification/dac_serial_frame_writer_tb.sv
// Self-checking bench for the frame writer
`timescale 1ns/10ps
module dac_serial_frame_writer_tb;
reg CLK_I, RESET_I, START_I, USE_BITBANG_I, MASTER_I, SCK_I, MOSI_I, SS_N_I;
reg [7:0] ADDR_I, DATA_I, SLAVE_TX_I;
wire MISO_I, SCK_O, SCK_OE_N_O, MOSI_O, MOSI_OE_N_O, MISO_O, MISO_OE_N_O, CS_N_O, BUSY_O, DONE_O, rx_v;
wire [2:0] PORT_O;
wire [7:0] rx, spi_n, bb_n;
wire [15:0] spi_w, bb_w;
wire [4:0] spi_b, bb_b;
wire [5:0] mode;
integer n_mismatch, compares;
dac_serial_frame_writer dut_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .START_I(START_I), .ADDR_I(ADDR_I),
	.DATA_I(DATA_I), .USE_BITBANG_I(USE_BITBANG_I), .MASTER_I(MASTER_I), .SLAVE_TX_I(SLAVE_TX_I), .SCK_I(SCK_I),
	.SCK_O(SCK_O), .SCK_OE_N_O(SCK_OE_N_O), .MOSI_I(MOSI_I), .MOSI_O(MOSI_O), .MOSI_OE_N_O(MOSI_OE_N_O),
	.MISO_I(MISO_I), .MISO_O(MISO_O), .MISO_OE_N_O(MISO_OE_N_O), .SS_N_I(SS_N_I), .CS_N_O(CS_N_O),
	.PORT_O(PORT_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .SLAVE_RX_O(rx), .SLAVE_RX_VALID_O(rx_v));
dac_chip_model spi_dac_u (.cs_n_i(CS_N_O), .sck_i(SCK_O), .din_i(MOSI_O), .dout_o(MISO_I),
	.word_o(spi_w), .bits_o(spi_b), .frames_o(spi_n), .mode_o(mode));
dac_chip_model bb_dac_u (.cs_n_i(PORT_O[0]), .sck_i(PORT_O[1]), .din_i(PORT_O[2]), .dout_o(),
	.word_o(bb_w), .bits_o(bb_b), .frames_o(bb_n), .mode_o());
initial
begin
	CLK_I = 1'b0;
	forever #50 CLK_I = ~CLK_I;
end
task end_of_test;
begin
	$display("Comparisons %0d mismatches %0d", compares, n_mismatch);
	if (n_mismatch == 0 && compares > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
end
endtask
task chk(input string what, input [15:0] exp, input [15:0] got);
begin
	compares = compares + 1;
	if (got !== exp)
	begin
		n_mismatch = n_mismatch + 1;
		$display("Error %s expected %h seen %h", what, exp, got);
	end
end
endtask
// ==========================================
// Scenarios
task frame(input bang, input [7:0] a, input [7:0] d);
	reg [7:0] f0;
	integer k;
begin
	f0 = bang ? bb_n : spi_n;
	@(posedge CLK_I);
	USE_BITBANG_I <= bang;
	ADDR_I <= a;
	DATA_I <= d;
	START_I <= 1'b1;
	@(posedge CLK_I);
	START_I <= 1'b0;
	repeat (4) @(negedge CLK_I);
	chk("busy", 16'h0001, {15'h0000, BUSY_O});
	// A request while busy must change nothing
	@(posedge CLK_I);
	START_I <= 1'b1;
	ADDR_I <= ~a;
	@(posedge CLK_I);
	START_I <= 1'b0;
	for (k = 0; k < 400 && DONE_O !== 1'b1; k = k + 1)
		@(negedge CLK_I);
	chk("done", 16'h0001, {15'h0000, DONE_O});
	if (DONE_O !== 1'b1)
		end_of_test;
	chk("busy", 16'h0000, {15'h0000, BUSY_O});
	repeat (2) @(negedge CLK_I);
	chk("word", {a, d}, bang ? bb_w : spi_w);
	chk("bits", 16'h0010, {11'h000, bang ? bb_b : spi_b});
	chk("frames", {8'h00, f0 + 8'h01}, {8'h00, bang ? bb_n : spi_n});
end
endtask
task slave(input [7:0] b);
	reg [7:0] got;
	integer n;
begin
	@(posedge CLK_I);
	MASTER_I <= 1'b0;
	SS_N_I <= 1'b0;
	repeat (6) @(posedge CLK_I);
	START_I <= 1'b1;
	@(posedge CLK_I);
	START_I <= 1'b0;
	repeat (4) @(negedge CLK_I);
	chk("busy", 16'h0000, {15'h0000, BUSY_O});
	chk("oe_n", 16'h0110, {7'h00, SCK_OE_N_O, 3'h0, MOSI_OE_N_O, 3'h0, MISO_OE_N_O});
	for (n = 7; n >= 0; n = n - 1)
	begin
		@(posedge CLK_I);
		SCK_I <= 1'b0;
		MOSI_I <= b[n];
		repeat (4) @(posedge CLK_I);
		@(negedge CLK_I);
		got[n] = MISO_O;
		@(posedge CLK_I);
		SCK_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
	end
	@(posedge CLK_I);
	SCK_I <= 1'b0;
	for (n = 0; n < 20 && rx_v !== 1'b1; n = n + 1)
		@(negedge CLK_I);
	chk("rx", {8'h01, b}, {7'h00, rx_v, rx});
	if (rx_v !== 1'b1)
		end_of_test;
	chk("miso", {8'h00, SLAVE_TX_I}, {8'h00, got});
	@(posedge CLK_I);
	SS_N_I <= 1'b1;
	MOSI_I <= ~MOSI_I;
	MASTER_I <= 1'b1;
	repeat (8) @(negedge CLK_I);
	chk("oe_n", 16'h0001, {7'h00, SCK_OE_N_O, 3'h0, MOSI_OE_N_O, 3'h0, MISO_OE_N_O});
end
endtask
initial
begin
	n_mismatch = 0;
	compares = 0;
	{RESET_I, MASTER_I, SS_N_I} = 3'h7;
	{START_I, USE_BITBANG_I, SCK_I, MOSI_I} = 4'h0;
	ADDR_I = 8'h00;
	DATA_I = 8'h00;
	SLAVE_TX_I = 8'h96;
	repeat (5) @(posedge CLK_I);
	RESET_I <= 1'b0;
	@(negedge CLK_I);
	chk("idle", 16'h0011, {11'h000, CS_N_O, 1'b0, PORT_O});
	frame(1'b0, 8'h00, 8'hBF);
	chk("mode", 16'h003F, {10'h000, mode});
	frame(1'b0, 8'h00, 8'h00);
	chk("mode", 16'h003F, {10'h000, mode});
	frame(1'b0, 8'hA5, 8'h3C);
	chk("chan", 16'h3C3C, {spi_dac_u.ch_reg[7], spi_dac_u.ch_reg[0]});
	frame(1'b1, 8'h5A, 8'hC3);
	frame(1'b1, 8'h80, 8'h01);
	slave(8'hB4);
	frame(1'b0, 8'hFF, 8'h81);
	frame(1'b0, 8'h02, 8'h11);
	chk("chan", 16'h1181, {spi_dac_u.ch_reg[1], spi_dac_u.ch_reg[0]});
	end_of_test;
end
endmodule // dac_serial_frame_writer_tb
